// file: cbeao_regs.vh
`ifndef CBEAO_REGS_VH
`define CBEAO_REGS_VH
// Behaviour
// RULE_01 - break loads trap opcode into instruction register
// RULE_02 - break vector FFFC, or FEFC in monitor
// RULE_03 - pending break waits for instruction end
// RULE_04 - match on last cycle enters break at once
// RULE_05 - return ends break once request is gone
// RULE_06 - add with carry, eight forms, five flags
// RULE_07 - add without carry, same forms and flags
// RULE_08 - signed immediate added to stack, two cycles
// RULE_09 - signed immediate added to index pair
// RULE_10 - and clears overflow, sets negative and zero
// RULE_11 - left shift, bit 7 to carry
// RULE_12 - right shift keeps sign, five forms; the core decodes six (direct, A, X, ix1, ix, sp1)
// RULE_13 - branch on carry clear, three cycles
// RULE_14 - clear one direct-page bit, four cycles
// RULE_15 - branch on carry set, three cycles
// RULE_16 - branch on zero set, three cycles
// RULE_17 - half-carry from bit 3 into 4
// RULE_18 - branch offset is signed, sign-extended

// ********************************
// opcodes
// ********************************
`define CBEAO_OP_TRAP   8'h83
`define CBEAO_OP_RETI   8'h80
`define CBEAO_OP_PREFIX 8'h9E
`define CBEAO_OP_STKADJ 8'hA7
`define CBEAO_OP_IDXADJ 8'hAF
`define CBEAO_OP_BR_CC  8'h24
`define CBEAO_OP_BR_CS  8'h25
`define CBEAO_OP_BR_EQ  8'h27
`define CBEAO_LO_ADC    4'h9
`define CBEAO_LO_ADD    4'hB
`define CBEAO_LO_AND    4'h4
`define CBEAO_LO_SHL    4'h8
`define CBEAO_LO_SHR    4'h7
`define CBEAO_HI_CLRB   4'h1
// row nibbles selecting the addressing form
`define CBEAO_HI_IMM    4'hA
`define CBEAO_HI_DIR    4'hB
`define CBEAO_HI_EXT    4'hC
`define CBEAO_HI_IX2    4'hD
`define CBEAO_HI_IX1    4'hE
`define CBEAO_HI_IX     4'hF
`define CBEAO_HI_SP1    4'hE
`define CBEAO_HI_SP2    4'hD
`define CBEAO_HS_DIR    4'h3
`define CBEAO_HS_INHA   4'h4
`define CBEAO_HS_INHX   4'h5
`define CBEAO_HS_IX1    4'h6
`define CBEAO_HS_IX     4'h7
`define CBEAO_HS_SP1    4'h6

// ********************************
// vectors and reset values
// ********************************
`define CBEAO_VEC_BRK   16'hFFFC
`define CBEAO_VEC_MON   16'hFEFC
`define CBEAO_VEC_RST   16'hFFFE
`define CBEAO_SP_RST    16'h00FF
`define CBEAO_CCR_RST   8'h68
`define CBEAO_CCR_ONES  8'h60

// ********************************
// flag positions
// ********************************
`define CBEAO_F_V 7
`define CBEAO_F_H 4
`define CBEAO_F_I 3
`define CBEAO_F_N 2
`define CBEAO_F_Z 1
`define CBEAO_F_C 0

// ********************************
// alu operations
// ********************************
`define CBEAO_ALU_ADD  3'h0
`define CBEAO_ALU_ADC  3'h1
`define CBEAO_ALU_AND  3'h2
`define CBEAO_ALU_SHL  3'h3
`define CBEAO_ALU_SHR  3'h4
`define CBEAO_ALU_CLRB 3'h5
`define CBEAO_ALU_PASS 3'h6

// ********************************
// cycle counts
// ********************************
`define CBEAO_CYC_IMM  4'h2
`define CBEAO_CYC_DIR  4'h3
`define CBEAO_CYC_EXT  4'h4
`define CBEAO_CYC_IX2  4'h4
`define CBEAO_CYC_IX1  4'h3
`define CBEAO_CYC_IX   4'h2
`define CBEAO_CYC_SP1  4'h4
`define CBEAO_CYC_SP2  4'h5
`define CBEAO_CYC_SDIR 4'h4
`define CBEAO_CYC_SINH 4'h1
`define CBEAO_CYC_SIX1 4'h4
`define CBEAO_CYC_SIX  4'h3
`define CBEAO_CYC_SSP1 4'h5
`define CBEAO_CYC_BR   4'h3
`define CBEAO_CYC_CLRB 4'h4
`define CBEAO_CYC_ADJ  4'h2
`define CBEAO_CYC_ONE  4'h1
`define CBEAO_STK_LAST 3'h4
`define CBEAO_STK_VEC  3'h5
`define CBEAO_PUL_LAST 3'h5

`endif

// file: cbeao_alu.v
`timescale 1ns/1ps
`include "cbeao_regs.vh"
module cbeao_alu (
	input  wire [2:0] op,
	input  wire [7:0] a,
	input  wire [7:0] m,
	input  wire [7:0] flags_in,
	input  wire [2:0] bitn,
	output reg  [7:0] res,
	output reg  [7:0] flags_out
);
	reg [8:0] sum;
	reg       cin;

	always @* begin
		sum = 9'h000;
		cin = (op == `CBEAO_ALU_ADC) ? flags_in[`CBEAO_F_C] : 1'b0;
		res = a;
		flags_out = flags_in;
		case (op)
		`CBEAO_ALU_ADD, `CBEAO_ALU_ADC: begin // [RULE_06] [RULE_07]
			sum = {1'b0, a} + {1'b0, m} + {8'h00, cin};
			res = sum[7:0];
			flags_out[`CBEAO_F_C] = sum[8];
			flags_out[`CBEAO_F_H] = a[4] ^ m[4] ^ sum[4]; // [RULE_17]
			flags_out[`CBEAO_F_V] = (a[7] & m[7] & ~sum[7]) |
				(~a[7] & ~m[7] & sum[7]);
			flags_out[`CBEAO_F_N] = sum[7];
			flags_out[`CBEAO_F_Z] = (sum[7:0] == 8'h00);
		end
		`CBEAO_ALU_AND: begin // [RULE_10]
			res = a & m;
			flags_out[`CBEAO_F_V] = 1'b0;
			flags_out[`CBEAO_F_N] = res[7];
			flags_out[`CBEAO_F_Z] = (res == 8'h00);
		end
		`CBEAO_ALU_SHL, `CBEAO_ALU_SHR: begin // [RULE_11] [RULE_12]
			if (op == `CBEAO_ALU_SHL) begin
				res = {a[6:0], 1'b0};
				flags_out[`CBEAO_F_C] = a[7];
			end else begin
				res = {a[7], a[7:1]};
				flags_out[`CBEAO_F_C] = a[0];
			end
			flags_out[`CBEAO_F_N] = res[7];
			flags_out[`CBEAO_F_Z] = (res == 8'h00);
			// overflow is sign xor carry after the shift
			flags_out[`CBEAO_F_V] = res[7] ^ flags_out[`CBEAO_F_C];
		end
		`CBEAO_ALU_CLRB: begin
			res = a & ~(8'h01 << bitn); // [RULE_14]
		end
		default: begin
			res = a;
		end
		endcase
	end
endmodule

// file: cbeao_core.v
`timescale 1ns/1ps
`include "cbeao_regs.vh"
module cbeao_core (
	input  wire        sys_clk,
	input  wire        sys_rst,
	input  wire [7:0]  mem_rdata,
	input  wire        brk_req,
	input  wire        monitor_mode,
	output reg  [15:0] mem_addr,
	output reg  [7:0]  mem_wdata,
	output reg         mem_rd,
	output reg         mem_wr,
	output reg         brk_active,
	output reg         instr_end,
	output reg  [7:0]  acc,
	output reg  [15:0] hx,
	output reg  [15:0] sp,
	output reg  [15:0] pc,
	output reg  [7:0]  condition_flags
);
	// ********************************
	// states
	// ********************************
	localparam S_OP  = 8'h01;
	localparam S_ARG = 8'h02;
	localparam S_MEM = 8'h04;
	localparam S_END = 8'h08;
	localparam S_STK = 8'h10;
	localparam S_PUL = 8'h20;
	localparam S_VL  = 8'h40;
	localparam S_VD  = 8'h80;

	reg [7:0]  state;
	reg [7:0]  ir;
	reg        pre;
	reg        argc;
	reg [7:0]  ea_hi;
	reg [3:0]  cyc;
	reg [2:0]  k;
	reg [15:0] vaddr;
	reg [3:0]  need;
	reg [7:0]  stk_byte;

	// ********************************
	// decode
	// ********************************
	// the opcode is decoded straight off the bus in its own cycle
	wire [7:0] dop = (state == S_OP) ? mem_rdata : ir;
	wire       dpre = pre;
	wire [3:0] hi = dop[7:4];
	wire [3:0] lo = dop[3:0];

	wire is_alu = (lo == `CBEAO_LO_ADC || lo == `CBEAO_LO_ADD ||
		lo == `CBEAO_LO_AND) && (dpre ?
		(hi == `CBEAO_HI_SP1 || hi == `CBEAO_HI_SP2) :
		(hi >= `CBEAO_HI_IMM));
	wire is_sh = (lo == `CBEAO_LO_SHL || lo == `CBEAO_LO_SHR) && (dpre ?
		(hi == `CBEAO_HS_SP1) :
		(hi >= `CBEAO_HS_DIR && hi <= `CBEAO_HS_IX));
	wire is_clrb = !dpre && hi == `CBEAO_HI_CLRB && lo[0];
	wire is_br = !dpre && (dop == `CBEAO_OP_BR_CC ||
		dop == `CBEAO_OP_BR_CS || dop == `CBEAO_OP_BR_EQ);
	wire is_adj = !dpre && (dop == `CBEAO_OP_STKADJ ||
		dop == `CBEAO_OP_IDXADJ);

	wire m_imm  = is_alu && !dpre && hi == `CBEAO_HI_IMM;
	wire m_dir  = (is_alu && !dpre && hi == `CBEAO_HI_DIR) ||
		(is_sh && !dpre && hi == `CBEAO_HS_DIR) || is_clrb;
	wire m_ext  = is_alu && !dpre && hi == `CBEAO_HI_EXT;
	wire m_ix2  = is_alu && !dpre && hi == `CBEAO_HI_IX2;
	wire m_ix1  = (is_alu && !dpre && hi == `CBEAO_HI_IX1) ||
		(is_sh && !dpre && hi == `CBEAO_HS_IX1);
	wire m_ix   = (is_alu && !dpre && hi == `CBEAO_HI_IX) ||
		(is_sh && !dpre && hi == `CBEAO_HS_IX);
	wire m_sp1  = dpre && ((is_alu && hi == `CBEAO_HI_SP1) || is_sh);
	wire m_sp2  = dpre && is_alu && hi == `CBEAO_HI_SP2;
	wire m_inha = is_sh && !dpre && hi == `CBEAO_HS_INHA;
	wire m_inhx = is_sh && !dpre && hi == `CBEAO_HS_INHX;
	wire two_arg = m_ext || m_ix2 || m_sp2;

	// ********************************
	// cycle budget per instruction
	// ********************************
	always @* begin
		need = `CBEAO_CYC_ONE;
		if (is_alu) begin
			need = m_imm ? `CBEAO_CYC_IMM :
				m_dir ? `CBEAO_CYC_DIR :
				m_ext ? `CBEAO_CYC_EXT :
				m_ix2 ? `CBEAO_CYC_IX2 :
				m_ix1 ? `CBEAO_CYC_IX1 :
				m_ix  ? `CBEAO_CYC_IX :
				m_sp1 ? `CBEAO_CYC_SP1 : `CBEAO_CYC_SP2;
		end else if (is_sh) begin // [RULE_11] [RULE_12]
			need = m_dir ? `CBEAO_CYC_SDIR :
				m_ix1 ? `CBEAO_CYC_SIX1 :
				m_ix  ? `CBEAO_CYC_SIX :
				m_sp1 ? `CBEAO_CYC_SSP1 : `CBEAO_CYC_SINH;
		end else if (is_br) begin
			need = `CBEAO_CYC_BR; // [RULE_13] [RULE_15] [RULE_16]
		end else if (is_clrb) begin
			need = `CBEAO_CYC_CLRB; // [RULE_14]
		end else if (is_adj) begin
			need = `CBEAO_CYC_ADJ; // [RULE_08] [RULE_09]
		end
	end

	// ********************************
	// operand paths
	// ********************************
	wire [15:0] sx = {{8{mem_rdata[7]}}, mem_rdata}; // [RULE_18]
	wire [15:0] word = {ea_hi, mem_rdata};
	wire [15:0] byte0 = {8'h00, mem_rdata};
	wire [15:0] ea_w = m_ext ? word :
		m_ix2 ? hx + word :
		m_ix1 ? hx + byte0 :
		m_sp1 ? sp + byte0 :
		m_sp2 ? sp + word : byte0;

	wire taken = (dop == `CBEAO_OP_BR_CC) ?
		!condition_flags[`CBEAO_F_C] :
		(dop == `CBEAO_OP_BR_CS) ? condition_flags[`CBEAO_F_C] :
		condition_flags[`CBEAO_F_Z];

	wire [2:0] alu_op = !is_alu ? (is_clrb ? `CBEAO_ALU_CLRB :
		!is_sh ? `CBEAO_ALU_PASS :
		(lo == `CBEAO_LO_SHL) ? `CBEAO_ALU_SHL : `CBEAO_ALU_SHR) :
		(lo == `CBEAO_LO_ADC) ? `CBEAO_ALU_ADC : // [RULE_06]
		(lo == `CBEAO_LO_ADD) ? `CBEAO_ALU_ADD : // [RULE_07]
		`CBEAO_ALU_AND;
	wire [7:0] alu_a = (is_alu || m_inha) ? acc :
		m_inhx ? hx[7:0] : mem_rdata;
	wire [7:0] alu_res;
	wire [7:0] alu_flg;

	cbeao_alu u_alu (
		.op        (alu_op),
		.a         (alu_a),
		.m         (mem_rdata),
		.flags_in  (condition_flags),
		.bitn      (dop[3:1]),
		.res       (alu_res),
		.flags_out (alu_flg)
	);

	wire [15:0] vec = (brk_active && monitor_mode) ?
		`CBEAO_VEC_MON : `CBEAO_VEC_BRK; // [RULE_02]

	always @* begin
		case (k)
		3'h0:    stk_byte = pc[7:0];
		3'h1:    stk_byte = pc[15:8];
		3'h2:    stk_byte = hx[7:0];
		3'h3:    stk_byte = acc;
		default: stk_byte = condition_flags;
		endcase
	end

	// ********************************
	// sequencing helpers
	// ********************************
	task rd;
		input [15:0] a;
		begin
			mem_addr <= a;
			mem_rd <= 1'b1;
		end
	endtask

	task fetch;
		begin
			rd(pc);
			pc <= pc + 16'h0001;
		end
	endtask

	// break is sampled only here, so it never splits an instruction
	task fin;
		input [15:0] a;
		begin
			pre <= 1'b0;
			cyc <= 4'h0;
			instr_end <= 1'b1;
			if (brk_req && !brk_active) begin // [RULE_03] [RULE_04]
				ir <= `CBEAO_OP_TRAP; // [RULE_01]
				brk_active <= 1'b1;
				k <= 3'h0;
				pc <= a;
				state <= S_STK;
			end else begin
				rd(a);
				pc <= a + 16'h0001;
				state <= S_OP;
			end
		end
	endtask

	task close;
		begin
			if (cyc + 4'h1 >= need)
				fin(pc);
			else
				state <= S_END;
		end
	endtask

	// ********************************
	// main sequencer
	// ********************************
	always @(posedge sys_clk) begin
		if (sys_rst) begin
			state <= S_VL;
			mem_addr <= `CBEAO_VEC_RST;
			mem_rd <= 1'b1;
			mem_wr <= 1'b0;
			mem_wdata <= 8'h00;
			vaddr <= `CBEAO_VEC_RST;
			brk_active <= 1'b0;
			instr_end <= 1'b0;
			acc <= 8'h00;
			hx <= 16'h0000;
			sp <= `CBEAO_SP_RST;
			pc <= 16'h0000;
			condition_flags <= `CBEAO_CCR_RST;
			ir <= 8'h00;
			pre <= 1'b0;
			argc <= 1'b0;
			ea_hi <= 8'h00;
			cyc <= 4'h0;
			k <= 3'h0;
		end else begin
			mem_rd <= 1'b0;
			mem_wr <= 1'b0;
			instr_end <= 1'b0;
			cyc <= cyc + 4'h1;
			case (state)
			S_OP: begin
				if (mem_rdata == `CBEAO_OP_PREFIX && !pre) begin
					pre <= 1'b1;
					fetch;
				end else begin
					ir <= mem_rdata;
					if (!pre && mem_rdata == `CBEAO_OP_TRAP) begin
						k <= 3'h0;
						state <= S_STK;
					end else if (!pre && mem_rdata == `CBEAO_OP_RETI) begin
						k <= 3'h0;
						state <= S_PUL;
					end else if (m_inha) begin
						acc <= alu_res; // [RULE_11] [RULE_12]
						condition_flags <= alu_flg;
						close;
					end else if (m_inhx) begin
						hx[7:0] <= alu_res;
						condition_flags <= alu_flg;
						close;
					end else if (m_ix) begin
						rd(hx);
						state <= S_MEM;
					end else if (is_alu || is_sh || is_clrb || is_br ||
						is_adj) begin
						argc <= 1'b0;
						fetch;
						state <= S_ARG;
					end else begin
						fin(pc);
					end
				end
			end
			S_ARG: begin
				if (two_arg && !argc) begin
					ea_hi <= mem_rdata;
					argc <= 1'b1;
					fetch;
				end else if (m_imm) begin
					acc <= alu_res;
					condition_flags <= alu_flg;
					close;
				end else if (is_adj) begin
					// flags are left alone by both adjusts
					if (dop == `CBEAO_OP_STKADJ)
						sp <= sp + sx; // [RULE_08]
					else
						hx <= hx + sx; // [RULE_09]
					close;
				end else if (is_br) begin
					// pc already points past the offset byte
					if (taken)
						pc <= pc + sx; // [RULE_13] [RULE_15] [RULE_16]
					state <= S_END;
				end else begin
					rd(ea_w);
					state <= S_MEM;
				end
			end
			S_MEM: begin
				if (is_alu) begin
					acc <= alu_res; // [RULE_06] [RULE_07] [RULE_10]
					condition_flags <= alu_flg;
					close;
				end else begin
					// write back to the address just read; memory
					// forms always pad, so no fetch competes here
					mem_wdata <= alu_res; // [RULE_14]
					mem_wr <= 1'b1;
					condition_flags <= alu_flg;
					state <= S_END;
				end
			end
			S_END: begin
				if (cyc + 4'h1 >= need)
					fin(pc);
			end
			S_STK: begin
				if (k == `CBEAO_STK_VEC) begin
					rd(vec);
					vaddr <= vec;
					state <= S_VL;
				end else begin
					mem_addr <= sp;
					mem_wdata <= stk_byte;
					mem_wr <= 1'b1;
					sp <= sp - 16'h0001;
					if (k == `CBEAO_STK_LAST)
						condition_flags[`CBEAO_F_I] <= 1'b1;
					k <= k + 3'h1;
				end
			end
			S_PUL: begin
				case (k)
				3'h1: condition_flags <= mem_rdata | `CBEAO_CCR_ONES;
				3'h2: acc <= mem_rdata;
				3'h3: hx[7:0] <= mem_rdata;
				3'h4: pc[15:8] <= mem_rdata;
				default: ;
				endcase
				if (k == `CBEAO_PUL_LAST) begin
					if (!brk_req)
						brk_active <= 1'b0; // [RULE_05]
					fin({pc[15:8], mem_rdata});
				end else begin
					rd(sp + 16'h0001);
					sp <= sp + 16'h0001;
					k <= k + 3'h1;
				end
			end
			S_VL: begin
				pc[15:8] <= mem_rdata;
				rd(vaddr + 16'h0001);
				state <= S_VD;
			end
			S_VD: begin
				fin({pc[15:8], mem_rdata});
			end
			default: begin
				fin(pc);
			end
			endcase
		end
	end
endmodule

// file: cbeao_mem_model.sv
`timescale 1ns/1ps
// ****************
// zero-wait memory
// ****************
module cbeao_mem_model (
	input  wire        sys_clk,
	input  wire [15:0] mem_addr,
	input  wire [7:0]  mem_wdata,
	input  wire        mem_rd,
	input  wire        mem_wr,
	output wire [7:0]  mem_rdata
);
	reg [7:0] store [0:65535];
	reg [7:0] junk;

	initial junk = 8'h5A;

	// the core takes read data at the edge after it raises the strobe, so
	// the byte stands only while the strobe does; junk that changes every
	// cycle shows up whenever the core samples outside that cycle
	assign mem_rdata = mem_rd ? store[mem_addr] : junk;

	always @(posedge sys_clk) begin
		if (mem_wr)
			store[mem_addr] <= mem_wdata;
		junk <= ~junk;
	end
endmodule

// file: cbeao_core_checker.sv
`timescale 1ns/1ps
module cbeao_core_checker (
	input wire        sys_clk,
	input wire        sys_rst,
	input wire [7:0]  mem_rdata,
	input wire        brk_req,
	input wire        monitor_mode,
	input wire [15:0] mem_addr,
	input wire        mem_rd,
	input wire        mem_wr,
	input wire        brk_active,
	input wire        instr_end,
	input wire [7:0]  acc,
	input wire [7:0]  condition_flags
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);

	reg        fetch_q;
	reg        act_q;
	reg  [7:0] op_q;
	// first cycle after the edge at which break was entered
	wire take   = instr_end && brk_active && !act_q;
	wire adj_op = op_q == 8'hA7 || op_q == 8'hAF;
	wire br_op  = op_q == 8'h24 || op_q == 8'h25 ||
		op_q == 8'h27;
	wire clr_op = op_q[7:4] == 4'h1 && op_q[0];

	// opcode captured at the edge that consumes it, so the antecedents
	// below sit one cycle into the instruction
	always @(posedge sys_clk) begin
		fetch_q <= !sys_rst && mem_rd && instr_end;
		act_q <= brk_active;
		op_q <= mem_rdata;
	end

	AST_BRK_STACK: assert property (take |=> mem_wr [*5])
		else $error("break stacking did not follow instruction end");
	AST_BRK_VEC: assert property (take |-> ##6 (mem_rd &&
		mem_addr == (monitor_mode ? 16'hFEFC : 16'hFFFC)))
		else $error("break vector address wrong");
	AST_BRK_ACT: assert property (take |-> $past(brk_req))
		else $error("break entered without a request");
	AST_BRK_HOLD: assert property (brk_active && brk_req |=> brk_active)
		else $error("break ended while request high");
	AST_ADJ_LEN: assert property (fetch_q && adj_op |-> ##1 instr_end)
		else $error("adjust length wrong");
	AST_ADJ_FLAGS: assert property (fetch_q && adj_op |->
		$stable(condition_flags) [*2])
		else $error("adjust changed flags");
	AST_BR_LEN: assert property (fetch_q && br_op |-> ##2 instr_end)
		else $error("branch length wrong");
	AST_BR_FLAGS: assert property (fetch_q && br_op |->
		$stable(condition_flags) [*3])
		else $error("branch changed flags");
	AST_CLR_LEN: assert property (fetch_q && clr_op |-> ##3 instr_end)
		else $error("bit clear length wrong");
	AST_AND_V: assert property (fetch_q && op_q == 8'hA4 |->
		##1 !condition_flags[7])
		else $error("and left overflow set");

	cover property (take);
	cover property (fetch_q && br_op);
	cover property (fetch_q && adj_op);
	cover property (brk_active && !brk_req ##[1:20] !brk_active);
endmodule

bind cbeao_core cbeao_core_checker chk (
	.sys_clk(sys_clk), .sys_rst(sys_rst), .mem_rdata(mem_rdata),
	.brk_req(brk_req), .monitor_mode(monitor_mode), .mem_addr(mem_addr),
	.mem_rd(mem_rd), .mem_wr(mem_wr), .brk_active(brk_active),
	.instr_end(instr_end), .acc(acc), .condition_flags(condition_flags)
);

// file: cbeao_core_bench.sv
`timescale 1ns/1ps
module cbeao_core_bench;
	reg         sys_clk;
	reg         sys_rst;
	reg         brk_req;
	reg         monitor_mode;
	wire [7:0]  mem_rdata;
	wire [15:0] mem_addr;
	wire [7:0]  mem_wdata;
	wire        mem_rd;
	wire        mem_wr;
	wire        brk_active;
	wire        instr_end;
	wire [7:0]  acc;
	wire [15:0] hx;
	wire [15:0] sp;
	wire [15:0] pc;
	wire [7:0]  flags;
	integer     bad_count;
	integer     tests_run;
	integer     cyc;
	integer     last;
	integer     gap;
	integer     i;

	always #25 sys_clk = ~sys_clk;
	always @(posedge sys_clk) cyc <= cyc + 1;

	cbeao_core dut (
		.sys_clk(sys_clk), .sys_rst(sys_rst), .mem_rdata(mem_rdata),
		.brk_req(brk_req), .monitor_mode(monitor_mode),
		.mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rd(mem_rd),
		.mem_wr(mem_wr), .brk_active(brk_active), .instr_end(instr_end),
		.acc(acc), .hx(hx), .sp(sp), .pc(pc), .condition_flags(flags)
	);
	cbeao_mem_model mem (
		.sys_clk(sys_clk), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
		.mem_rd(mem_rd), .mem_wr(mem_wr), .mem_rdata(mem_rdata)
	);

	// ****************
	// helpers
	// ****************
	task results;
		begin
			$display("checks %0d mismatches %0d", tests_run, bad_count);
			if (bad_count == 0 && tests_run > 0)
				$display("Testbench passed");
			else
				$display("Testbench failed");
			$finish;
		end
	endtask

	task check(input [15:0] seen, input [15:0] exp);
		begin
			tests_run = tests_run + 1;
			if (seen !== exp) begin
				bad_count = bad_count + 1;
				$display("CHECK FAILED t=%0t seen %h want %h", $time, seen, exp);
			end
		end
	endtask

	task put4(input [15:0] a, input [31:0] v);
		integer j;
		begin
			for (j = 0; j < 4; j = j + 1)
				mem.store[a + j] = v[31 - 8 * j -: 8];
		end
	endtask

	// vectors: break 0200, reset 0100, monitor 0300; handlers are returns
	task start(input [31:0] p0, input [31:0] p1);
		begin
			for (i = 0; i < 65536; i = i + 1)
				mem.store[i] = 8'h00;
			put4(16'hFFFC, 32'h02000100);
			put4(16'hFEFC, 32'h03000000);
			put4(16'h0200, 32'h80000000);
			put4(16'h0300, 32'h80000000);
			put4(16'h0100, p0);
			put4(16'h0104, p1);
			sys_rst = 1'b1;
			repeat (6) @(negedge sys_clk);
			sys_rst = 1'b0;
		end
	endtask

	// opcode fetch coincides with the end of the previous instruction
	task wait_fetch(input [15:0] a);
		integer n;
		begin
			n = 0;
			@(negedge sys_clk);
			while (!(instr_end === 1'b1 && mem_rd === 1'b1 &&
				mem_addr === a) && n < 600) begin
				@(negedge sys_clk);
				n = n + 1;
			end
			check((n < 600) ? mem_addr : ~a, a);
			gap = cyc - last;
			last = cyc;
		end
	endtask

	// ****************
	// scenarios
	// ****************
	task s_add;
		begin
			start(32'hAB0FAB01, 32'hABF0A905);
			wait_fetch(16'h0102);
			wait_fetch(16'h0104);
			check(acc, 16'h0010);
			check(flags, 16'h0078);
			wait_fetch(16'h0106);
			check(gap[15:0], 16'h0002);
			check(acc, 16'h0000);
			check(flags, 16'h006B);
			wait_fetch(16'h0108);
			check(acc, 16'h0006);
			check(flags, 16'h0068);
		end
	endtask

	task s_adj;
		begin
			start(32'hA780AF7F, 32'h00000000);
			wait_fetch(16'h0102);
			check(sp, 16'h007F);
			wait_fetch(16'h0104);
			check(gap[15:0], 16'h0002);
			check(hx, 16'h007F);
			check(flags, 16'h0068);
		end
	endtask

	task s_logic;
		begin
			start(32'hABC3A481, 32'h474848A4);
			wait_fetch(16'h0102);
			wait_fetch(16'h0104);
			check(acc, 16'h0081);
			check(flags, 16'h006C);
			wait_fetch(16'h0105);
			check(acc, 16'h00C0);
			check(flags, 16'h006D);
			wait_fetch(16'h0106);
			check(gap[15:0], 16'h0001);
			check(acc, 16'h0080);
			wait_fetch(16'h0107);
			check(acc, 16'h0000);
			check(flags, 16'h00EB);
			wait_fetch(16'h0109);
			check(acc, 16'h0000);
			check(flags, 16'h006B);
		end
	endtask

	task s_mem;
		begin
			start(32'h38401F40, 32'h00000000);
			mem.store[16'h0040] = 8'hFF;
			wait_fetch(16'h0102);
			check(mem.store[16'h0040], 16'h00FE);
			check(flags, 16'h006D);
			wait_fetch(16'h0104);
			check(gap[15:0], 16'h0004);
			check(mem.store[16'h0040], 16'h007E);
			check(flags, 16'h006D);
		end
	endtask

	task s_branch;
		begin
			start(32'hAB002402, 32'h251027FC);
			wait_fetch(16'h0102);
			wait_fetch(16'h0106);
			check(gap[15:0], 16'h0003);
			wait_fetch(16'h0104);
			check(gap[15:0], 16'h0003);
			wait_fetch(16'h0106);
			check(gap[15:0], 16'h0003);
			check(flags, 16'h006A);
		end
	endtask

	// carry set: carry-clear falls through, carry-set jumps backwards
	task s_branch_back;
		begin
			start(32'hABFFAB01, 32'h247F25FC);
			wait_fetch(16'h0104);
			wait_fetch(16'h0106);
			check(gap[15:0], 16'h0003);
			wait_fetch(16'h0104);
			check(gap[15:0], 16'h0003);
			check(flags, 16'h007B);
		end
	endtask

	// request raised in an add's first cycle waits for its end; a return
	// with the request high keeps the break, a later trap and return end it
	task s_break(input m);
		begin
			monitor_mode = m;
			start(32'hAB010083, 32'h00000000);
			wait_fetch(16'h0100);
			brk_req = 1'b1;
			wait_fetch(m ? 16'h0300 : 16'h0200);
			check(brk_active, 16'h0001);
			check(mem.store[16'h00FF], 16'h0002);
			check(mem.store[16'h00FE], 16'h0001);
			check(mem.store[16'h00FC], 16'h0001);
			check(sp, 16'h00FA);
			wait_fetch(16'h0102);
			check(brk_active, 16'h0001);
			brk_req = 1'b0;
			wait_fetch(m ? 16'h0300 : 16'h0200);
			wait_fetch(16'h0104);
			check(brk_active, 16'h0000);
			monitor_mode = 1'b0;
		end
	endtask

	initial begin
		sys_clk = 1'b0;
		sys_rst = 1'b1;
		brk_req = 1'b0;
		monitor_mode = 1'b0;
		bad_count = 0;
		tests_run = 0;
		cyc = 0;
		last = 0;
		gap = 0;
		s_add;
		s_adj;
		s_logic;
		s_mem;
		s_branch;
		s_branch_back;
		s_break(1'b0);
		s_break(1'b1);
		results;
	end

	initial begin
		#3000000;
		bad_count = bad_count + 1;
		results;
	end
endmodule
